// File: hdl/pcs_sequencer.sv
// program counter, rom fetch and table read sequencer
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ns
//
// Behaviour
// - 2K rom, vectors 0000h/0008h, top words reserved
// - reset vector is one word, normally jump
// - any reset restores registers, fetch from 0000h
// - power-on reset: timeout 1, powerdown 0
// - watchdog reset: timeout 0, powerdown 0
// - external reset: timeout 1, powerdown 1
// - reset cause flags readable in status flags
// - interrupt pushes pc, fetches at 0008h
// - save/restore acc and flags, not cause bits
// - single save buffer; second save overwrites
// - table address is high index : low index
// - table read: low byte to acc, high to r
// - low index wrap leaves high index alone
// - pcl plus acc carry increments pch
// - pcl minus acc borrow leaves pch
// - pc readable, writable as two byte registers
// - return address stack holds four levels
// - index registers are also working/indirect pointer
module pcs_sequencer
    import pcs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic        clk_sys,       // system clock, 100 MHz
    input  wire logic        sys_rst,       // power-on reset, sync, high
    input  wire logic        ext_rst_n_pin, // external reset pin, low
    input  wire logic        wdt_ovf,       // watchdog overflow pulse
    input  pcs_op_t          cmd_op,        // decoder command
    input  wire logic [10:0] cmd_target,    // jump or call target
    input  wire logic [15:0] rom_rdata,     // word at rom_addr
    input  wire logic [7:0]  reg_addr,      // register address
    input  wire logic [7:0]  reg_wdata,     // register write data
    input  wire logic        reg_wr,        // register write strobe
    input  wire logic        reg_rd,        // register read strobe
    output logic      [7:0]  reg_rdata,     // read data, next cycle
    output logic      [10:0] rom_addr,      // program memory address
    output logic             busy,          // table read in progress
    output logic      [7:0]  acc,           // accumulator
    output logic      [7:0]  work_r,        // table high byte / work
    output logic      [7:0]  index_y,       // high index, indirect ptr
    output logic      [7:0]  index_z,       // low index, indirect ptr
    output logic      [7:0]  status_flags,  // program_status_flags
    output logic             rsvd_fetch     // fetch hit reserved area
);
    typedef enum logic [0:0] {
        ST_RUN,
        ST_TABLE
    } pcs_state_t;

    pcs_state_t      state;
    pcs_state_t      next_state;
    logic [10:0]     pc;
    logic [10:0]     next_pc;
    logic [10:0]     next_rom_addr;
    logic [8:0]      pcl_sum;
    logic [7:0]      pcl_diff;
    logic [7:0]      save_acc;
    logic [7:0]      save_flags;
    logic [2:0]      ext_sync;
    logic            ext_active;
    logic            restart;
    logic            run_cmd;
    logic            rsvd_clear;
    logic [10:0]     pc_plus_one;
    logic [7:0]      flags_wmask;
    pcs_stack_if     stk_if ();

    pcs_stack #(
        .DEPTH (DEPTH)
    ) u_stack (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst | restart),
        .stk     (stk_if.stack_side)
    );

    function automatic logic hit(input logic [7:0] ofs);
        hit = (reg_addr == ofs);
    endfunction

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = reg_wr && (reg_addr == ofs);
    endfunction

    // commands count only while no table read holds the core
    function automatic logic take_op(input pcs_op_t op);
        take_op = run_cmd && (cmd_op == op);
    endfunction

    // reset cause in the top two flag bits, alu bits cleared
    function automatic logic [7:0] cause_word(input logic [1:0] cause);
        cause_word = {cause, 6'h00};
    endfunction

    // reset pin: three stages, a level change counts once 2nd and 3rd agree
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_sync <= 3'b111;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_rst_n_pin};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_active <= 1'b0;
        end else if (ext_sync[1] == ext_sync[2]) begin
            ext_active <= ~ext_sync[2];
        end
    end

    // held low the pin keeps the core at the reset vector
    assign restart = ext_active | wdt_ovf;
    assign run_cmd = (state == ST_RUN);

    assign pcl_sum  = {1'b0, pc[7:0]} + {1'b0, acc};
    assign pcl_diff = pc[7:0] - acc;
    // a call returns to the word after itself
    assign pc_plus_one = pc + PC_STEP;

    // write one clears the status bit; a new hit in that cycle wins
    assign rsvd_clear = reg_wr && (reg_addr == OFS_STATUS)
                        && reg_wdata[STS_RSVD];

    // next fetch address and stack traffic
    always_comb begin
        next_pc            = pc;
        stk_if.push        = 1'b0;
        stk_if.pop         = 1'b0;
        stk_if.push_pc     = pc;
        if (run_cmd) begin
            case (cmd_op)
                OP_STEP, OP_TABLE, OP_SAVE, OP_RESTORE, OP_INC_Z: begin
                    next_pc = pc_plus_one;
                end
                OP_JUMP: begin
                    next_pc = cmd_target;
                end
                OP_CALL: begin
                    stk_if.push    = 1'b1;
                    stk_if.push_pc = pc_plus_one;
                    next_pc        = cmd_target;
                end
                OP_IRQ: begin
                    stk_if.push    = 1'b1;
                    stk_if.push_pc = pc;
                    next_pc        = IRQ_VEC;
                end
                OP_RET, OP_INTERRUPT_RETURN: begin
                    stk_if.pop = 1'b1;
                    next_pc    = stk_if.top_pc;
                end
                OP_ADD_PCL: begin
                    next_pc = {pc[10:8] + {2'b00, pcl_sum[8]},
                               pcl_sum[7:0]};
                end
                OP_SUB_PCL: begin
                    next_pc = {pc[10:8], pcl_diff};
                end
                default: begin
                    next_pc = pc;
                end
            endcase
        end
        // software write to the pc bytes takes effect as a jump
        if (wr_hit(OFS_PC_LOW)) begin
            next_pc[7:0] = reg_wdata;
        end
        if (wr_hit(OFS_PC_HIGH)) begin
            next_pc[10:8] = reg_wdata[2:0];
        end
    end

    always_comb begin
        next_state    = state;
        next_rom_addr = next_pc;
        case (state)
            ST_RUN: begin
                if (take_op(OP_TABLE)) begin
                    next_state    = ST_TABLE;
                    // upper index bits beyond the rom fold away
                    next_rom_addr = {index_y[2:0], index_z};
                end
            end
            ST_TABLE: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // busy mirrors the table state so software can poll it
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_state == ST_TABLE);
        end
    end

    // the reset vector holds one word; fetch restarts there
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            pc <= RESET_VEC;
        end else begin
            pc <= next_pc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            rom_addr <= RESET_VEC;
        end else begin
            rom_addr <= next_rom_addr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            rsvd_fetch <= 1'b0;
        end else if (next_state == ST_RUN && next_pc >= RSVD_BASE) begin
            rsvd_fetch <= 1'b1;
        end else if (rsvd_clear) begin
            rsvd_fetch <= 1'b0;
        end
    end

    // accumulator: table low byte, restore, or software
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            acc <= REG_RST;
        end else if (state == ST_TABLE) begin
            acc <= rom_rdata[7:0];
        end else if (take_op(OP_RESTORE)) begin
            acc <= save_acc;
        end else if (wr_hit(OFS_ACC)) begin
            acc <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            work_r <= REG_RST;
        end else if (state == ST_TABLE) begin
            work_r <= rom_rdata[15:8];
        end else if (wr_hit(OFS_WORK_R)) begin
            work_r <= reg_wdata;
        end
    end

    // index registers double as working registers and data pointer
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            index_z <= REG_RST;
        end else if (wr_hit(OFS_INDEX_Z)) begin
            index_z <= reg_wdata;
        end else if (take_op(OP_INC_Z)) begin
            index_z <= index_z + 8'h01;
        end
    end

    // no carry path from the low index: software owns that
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            index_y <= REG_RST;
        end else if (wr_hit(OFS_INDEX_Y)) begin
            index_y <= reg_wdata;
        end
    end

    // one buffer only: a nested save silently replaces the outer one
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            save_acc <= REG_RST;
        end else if (take_op(OP_SAVE)) begin
            save_acc <= acc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) begin
            save_flags <= REG_RST;
        end else if (take_op(OP_SAVE)) begin
            save_flags <= status_flags & FLG_ALU_MASK;
        end
    end

    assign flags_wmask = FLG_ALU_MASK;

    // cause bits change only on a reset; software cannot write them
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_flags <= cause_word(CAUSE_POR);
        end else if (ext_active) begin
            status_flags <= cause_word(CAUSE_EXT);
        end else if (wdt_ovf) begin
            status_flags <= cause_word(CAUSE_WDT);
        end else if (take_op(OP_RESTORE)) begin
            status_flags <= (status_flags & ~flags_wmask)
                          | (save_flags & flags_wmask);
        end else if (wr_hit(OFS_FLAGS)) begin
            status_flags <= (status_flags & ~flags_wmask)
                          | (reg_wdata & flags_wmask);
        end
    end

    // read port: data stands in the cycle after the strobe only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= REG_RST;
        end else if (!reg_rd) begin
            reg_rdata <= REG_RST;
        end else if (hit(OFS_FLAGS)) begin
            reg_rdata <= status_flags;
        end else if (hit(OFS_PC_LOW)) begin
            reg_rdata <= pc[7:0];
        end else if (hit(OFS_PC_HIGH)) begin
            reg_rdata <= {5'h00, pc[10:8]};
        end else if (hit(OFS_INDEX_Y)) begin
            reg_rdata <= index_y;
        end else if (hit(OFS_INDEX_Z)) begin
            reg_rdata <= index_z;
        end else if (hit(OFS_WORK_R)) begin
            reg_rdata <= work_r;
        end else if (hit(OFS_ACC)) begin
            reg_rdata <= acc;
        end else if (hit(OFS_STATUS)) begin
            reg_rdata <= {busy, rsvd_fetch, 3'h0, stk_if.level};
        end else begin
            reg_rdata <= REG_RST;
        end
    end
endmodule

// File: hdl/pcs_pkg.sv
// shared constants and types of the program counter and rom sequencer
package pcs_pkg;

    // program memory map
    localparam int          PC_W         = 11;
    localparam int          ROM_WORDS    = 2048;
    localparam logic [10:0] RESET_VEC    = 11'h000;
    localparam logic [10:0] IRQ_VEC      = 11'h008;
    localparam logic [10:0] USER_BASE    = 11'h010;
    localparam logic [10:0] RSVD_BASE    = 11'h7fd;
    localparam logic [10:0] PC_STEP      = 11'h001;

    // hardware return stack
    localparam int          STACK_DEPTH  = 4;
    localparam int          LEVEL_W      = 3;

    // system register offsets
    localparam logic [7:0]  OFS_WORK_R   = 8'h82;
    localparam logic [7:0]  OFS_INDEX_Z  = 8'h83;
    localparam logic [7:0]  OFS_INDEX_Y  = 8'h84;
    localparam logic [7:0]  OFS_FLAGS    = 8'h86;
    localparam logic [7:0]  OFS_STATUS   = 8'hc6;
    localparam logic [7:0]  OFS_ACC      = 8'hc7;
    localparam logic [7:0]  OFS_PC_LOW   = 8'hce;
    localparam logic [7:0]  OFS_PC_HIGH  = 8'hcf;

    // program_status_flags field positions
    localparam int          FLG_TIMEOUT  = 7;
    localparam int          FLG_PDOWN    = 6;
    localparam int          FLG_CARRY    = 2;
    localparam int          FLG_DCARRY   = 1;
    localparam int          FLG_ZERO     = 0;
    localparam logic [7:0]  FLG_ALU_MASK = 8'h07;

    // status register field positions
    localparam int          STS_BUSY     = 7;
    localparam int          STS_RSVD     = 6;
    localparam int          STS_LVL_LSB  = 0;

    // reset values
    localparam logic [7:0]  REG_RST      = 8'h00;
    localparam logic [1:0]  CAUSE_POR    = 2'b10;
    localparam logic [1:0]  CAUSE_WDT    = 2'b00;
    localparam logic [1:0]  CAUSE_EXT    = 2'b11;

    // one command from the instruction decoder per cycle
    typedef enum logic [3:0] {
        OP_NONE,
        OP_STEP,
        OP_JUMP,
        OP_CALL,
        OP_RET,
        OP_IRQ,
        OP_INTERRUPT_RETURN,
        OP_TABLE,
        OP_ADD_PCL,
        OP_SUB_PCL,
        OP_SAVE,
        OP_RESTORE,
        OP_INC_Z
    } pcs_op_t;

endpackage

// File: hdl/pcs_stack_if.sv
// link between the sequencer and its return address stack
`timescale 1ns/1ns
interface pcs_stack_if;
    import pcs_pkg::*;
    logic               push;
    logic               pop;
    logic [PC_W-1:0]    push_pc;
    logic [PC_W-1:0]    top_pc;
    logic [LEVEL_W-1:0] level;
    modport seq_side   (output push, pop, push_pc, input top_pc, level);
    modport stack_side (input push, pop, push_pc, output top_pc, level);
endinterface

// File: hdl/pcs_stack.sv
// circular return address stack of fixed depth
`timescale 1ns/1ns
module pcs_stack
    import pcs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic     clk_sys,  // system clock
    input wire logic     sys_rst,  // synchronous reset
    pcs_stack_if.stack_side stk    // push and pop port
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [LEVEL_W-1:0] FULL = LEVEL_W'(DEPTH);

    logic [PC_W-1:0]  mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] top_ptr;

    assign top_ptr = wr_ptr - PTR_W'(1);
    assign stk.top_pc = mem[top_ptr];

    // a fifth push overwrites the oldest entry instead of stalling
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_ptr <= '0;
        end else if (stk.push) begin
            wr_ptr <= wr_ptr + PTR_W'(1);
        end else if (stk.pop) begin
            wr_ptr <= top_ptr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (stk.push) begin
            mem[wr_ptr] <= stk.push_pc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stk.level <= '0;
        end else if (stk.push && stk.level != FULL) begin
            stk.level <= stk.level + LEVEL_W'(1);
        end else if (stk.pop && !stk.push && stk.level != '0) begin
            stk.level <= stk.level - LEVEL_W'(1);
        end
    end
endmodule

// File: verif/pcs_sequencer_monitor.sv
// assertion checker for the program counter sequencer
`timescale 1ns/1ns
module pcs_sequencer_monitor
    import pcs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic        clk_sys,       // clock
    input wire logic        sys_rst,       // reset
    input wire logic        ext_rst_n_pin, // external reset
    input wire logic        wdt_ovf,       // watchdog pulse
    input pcs_op_t          cmd_op,        // command
    input wire logic [10:0] cmd_target,    // jump target
    input wire logic [15:0] rom_rdata,     // rom word
    input wire logic [7:0]  reg_addr,      // register address
    input wire logic [7:0]  reg_wdata,     // write data
    input wire logic        reg_wr,        // write strobe
    input wire logic        reg_rd,        // read strobe
    input wire logic [7:0]  reg_rdata,     // read data
    input wire logic [10:0] rom_addr,      // fetch address
    input wire logic        busy,          // table busy
    input wire logic [7:0]  acc,           // accumulator
    input wire logic [7:0]  work_r,        // table high byte
    input wire logic [7:0]  index_y,       // high index
    input wire logic [7:0]  index_z,       // low index
    input wire logic [7:0]  status_flags,  // status flags
    input wire logic        rsvd_fetch     // reserved hit
);
    logic [2:0] ext_hi;
    logic       pc_wr;
    logic       quiet;

    // the pin passes a synchroniser, so wait until its release has landed
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !ext_rst_n_pin)
            ext_hi <= 3'h0;
        else if (ext_hi != 3'h7)
            ext_hi <= ext_hi + 3'h1;
    end

    assign pc_wr = reg_wr && (reg_addr == OFS_PC_LOW
                              || reg_addr == OFS_PC_HIGH);
    assign quiet = !busy && !wdt_ovf && ext_hi >= 3'h5 && !pc_wr;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    wdt_restart_a: assert property (
        wdt_ovf && ext_hi >= 3'h5 |=> rom_addr == RESET_VEC
            && status_flags == 8'h00 && acc == REG_RST)
        else $error("watchdog restart wrong");
    irq_vector_a: assert property (
        quiet && cmd_op == OP_IRQ |=> rom_addr == IRQ_VEC)
        else $error("interrupt vector wrong");
    jump_target_a: assert property (
        quiet && cmd_op == OP_JUMP |=> rom_addr == $past(cmd_target))
        else $error("jump target wrong");
    add_carry_a: assert property (
        quiet && cmd_op == OP_ADD_PCL |=> rom_addr ==
            {$past(rom_addr[10:8]), 8'h00} + {3'h0, $past(rom_addr[7:0])}
            + {3'h0, $past(acc)})
        else $error("pc add wrong");
    sub_borrow_a: assert property (
        quiet && cmd_op == OP_SUB_PCL |=> $stable(rom_addr[10:8])
            && rom_addr[7:0] == $past(rom_addr[7:0]) - $past(acc))
        else $error("pc subtract wrong");
    table_read_a: assert property (
        quiet && cmd_op == OP_TABLE |=> (busy
            && rom_addr == {$past(index_y[2:0]), $past(index_z)})
            ##1 (!busy && acc == $past(rom_rdata[7:0])
            && work_r == $past(rom_rdata[15:8])))
        else $error("table read wrong");
    low_index_wrap_a: assert property (
        quiet && cmd_op == OP_INC_Z |=> $stable(index_y)
            && index_z == $past(index_z) + 8'h01)
        else $error("index increment wrong");
    flags_read_a: assert property (
        reg_rd && reg_addr == OFS_FLAGS |=> reg_rdata == $past(status_flags))
        else $error("flag read wrong");
    read_idle_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    pc_low_write_a: assert property (
        reg_wr && reg_addr == OFS_PC_LOW && !wdt_ovf && ext_hi >= 3'h5
            |=> rom_addr[7:0] == $past(reg_wdata))
        else $error("pc low write wrong");
endmodule

bind pcs_sequencer pcs_sequencer_monitor #(.DEPTH(DEPTH)) u_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ext_rst_n_pin(ext_rst_n_pin),
    .wdt_ovf(wdt_ovf), .cmd_op(cmd_op), .cmd_target(cmd_target),
    .rom_rdata(rom_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rom_addr(rom_addr), .busy(busy), .acc(acc), .work_r(work_r),
    .index_y(index_y), .index_z(index_z), .status_flags(status_flags),
    .rsvd_fetch(rsvd_fetch));

// File: verif/pcs_sequencer_test.sv
// self-checking bench for the program counter sequencer
`timescale 1ns/1ns
module pcs_sequencer_test;
    import pcs_pkg::*;
    typedef struct {
        pcs_op_t     op;
        logic [10:0] tgt;
        logic [10:0] exp;
    } pcs_row_t;
    logic        clk_sys       = 1'b0;
    logic        sys_rst       = 1'b1;
    logic        ext_rst_n_pin = 1'b1;
    logic        wdt_ovf       = 1'b0;
    pcs_op_t     cmd_op        = OP_NONE;
    logic [10:0] cmd_target    = 11'h000;
    logic [7:0]  reg_addr      = 8'h00;
    logic [7:0]  reg_wdata     = 8'h00;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic [15:0] rom_rdata;
    logic [7:0]  reg_rdata, acc, work_r, index_y, index_z, status_flags;
    logic [10:0] rom_addr;
    logic        busy, rsvd_fetch;
    int          bad_count     = 0;
    int          n_tests       = 0;
    pcs_row_t    rows [12];

    always #5 clk_sys = ~clk_sys;
    // every rom word is distinct, so a wrong table address shows up
    assign rom_rdata = {5'h00, rom_addr} ^ 16'h5a3c;

    pcs_sequencer dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ext_rst_n_pin(ext_rst_n_pin),
        .wdt_ovf(wdt_ovf), .cmd_op(cmd_op), .cmd_target(cmd_target),
        .rom_rdata(rom_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rom_addr(rom_addr), .busy(busy), .acc(acc), .work_r(work_r),
        .index_y(index_y), .index_z(index_z), .status_flags(status_flags),
        .rsvd_fetch(rsvd_fetch));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string w, input logic [15:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic cmd(input pcs_op_t op, input logic [10:0] t);
        @(posedge clk_sys);
        cmd_op     <= op;
        cmd_target <= t;
        @(posedge clk_sys);
        cmd_op <= OP_NONE;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask

    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    initial begin
        // calls push pc plus one, the interrupt pushes pc itself
        rows = '{'{OP_JUMP, 11'h100, 11'h100}, '{OP_STEP, 11'h000, 11'h101},
                 '{OP_CALL, 11'h200, 11'h200}, '{OP_CALL, 11'h300, 11'h300},
                 '{OP_CALL, 11'h400, 11'h400}, '{OP_CALL, 11'h500, 11'h500},
                 '{OP_RET, 11'h000, 11'h401}, '{OP_RET, 11'h000, 11'h301},
                 '{OP_RET, 11'h000, 11'h201}, '{OP_RET, 11'h000, 11'h102},
                 '{OP_IRQ, 11'h000, IRQ_VEC}, '{OP_INTERRUPT_RETURN, 11'h000, 11'h102}};
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("rom_addr", RESET_VEC, rom_addr);
        chk("flags", 8'h80, status_flags);
        repeat (6) @(posedge clk_sys);
        rd(OFS_FLAGS, 8'h80);
        foreach (rows[i]) begin
            cmd(rows[i].op, rows[i].tgt);
            chk("rom_addr", rows[i].exp, rom_addr);
        end
        chk("rsvd_fetch", 1'b0, rsvd_fetch);
        wr(OFS_ACC, 8'h10);
        wr(OFS_PC_LOW, 8'hf8);
        wr(OFS_PC_HIGH, 8'hf9);
        rd(OFS_PC_LOW, 8'hf8);
        rd(OFS_PC_HIGH, 8'h01);
        cmd(OP_ADD_PCL, 11'h000);
        chk("rom_addr", 11'h208, rom_addr);
        cmd(OP_SUB_PCL, 11'h000);
        chk("rom_addr", 11'h2f8, rom_addr);
        wr(OFS_INDEX_Y, 8'hf9);
        wr(OFS_INDEX_Z, 8'h23);
        rd(OFS_INDEX_Z, 8'h23);
        cmd(OP_TABLE, 11'h000);
        chk("rom_addr", 11'h123, rom_addr);
        chk("busy", 1'b1, busy);
        for (int k = 0; k < 4 && busy !== 1'b0; k++) begin
            @(posedge clk_sys);
            #1;
        end
        #1;
        chk("busy", 1'b0, busy);
        chk("acc", 8'h1f, acc);
        chk("work_r", 8'h5b, work_r);
        wr(OFS_INDEX_Z, 8'hff);
        cmd(OP_INC_Z, 11'h000);
        chk("index_z", 8'h00, index_z);
        chk("index_y", 8'hf9, index_y);
        wr(OFS_ACC, 8'h11);
        wr(OFS_FLAGS, 8'h05);
        cmd(OP_SAVE, 11'h000);
        wr(OFS_ACC, 8'h22);
        wr(OFS_FLAGS, 8'h02);
        cmd(OP_SAVE, 11'h000);
        wr(OFS_ACC, 8'h33);
        wr(OFS_FLAGS, 8'h07);
        cmd(OP_RESTORE, 11'h000);
        chk("acc", 8'h22, acc);
        chk("flags", 8'h82, status_flags);
        cmd(OP_JUMP, RSVD_BASE);
        @(posedge clk_sys);
        #1;
        chk("rsvd_fetch", 1'b1, rsvd_fetch);
        rd(OFS_STATUS, 8'h40);
        cmd(OP_JUMP, USER_BASE);
        wr(OFS_STATUS, 8'h40);
        #1;
        chk("rsvd_fetch", 1'b0, rsvd_fetch);
        @(posedge clk_sys);
        wdt_ovf <= 1'b1;
        @(posedge clk_sys);
        wdt_ovf <= 1'b0;
        #1;
        chk("rom_addr", RESET_VEC, rom_addr);
        chk("flags", 8'h00, status_flags);
        chk("acc", 8'h00, acc);
        @(posedge clk_sys);
        ext_rst_n_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("flags", 8'hc0, status_flags);
        chk("rom_addr", RESET_VEC, rom_addr);
        @(posedge clk_sys);
        ext_rst_n_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b1;
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("flags", 8'h80, status_flags);
        chk("index_y", 8'h00, index_y);
        rd(8'h90, 8'h00);
        end_of_test();
    end
endmodule
